// ---- core/dspwm_defs.svh ----
// constants for the dual-slope pwm compare output block
// Functional notes
// - dual-slope buffered compares load at bottom in 8/9, at top otherwise
// - action two non-inverted, three inverted in dual-slope
// - pin driven only when direction bit says output
// - dual-slope match action depends on count direction
// - dual-slope period is two times divisor times top
// - dual-slope compare at bottom or top gives steady level
// - mode 9 action 1 toggles chan A, half duty
// - timer tick is only an enable on mclk
// - nonzero action field takes the pin over, action 1 only where toggle exists
// - non-pwm actions: port, toggle, clear, set
// - fast pwm: match and bottom set or clear output
// - fast action 1 toggles chan A only in 14/15
// - fast pwm ignores match at top except for action 1, keeps bottom action
// - action field decoded per current wave mode class
// - dual-slope counts up to top then down; top source
// - dual-slope wrap flag at bottom, capture flag at top in 8/10
`ifndef DSPWM_DEFS_SVH
`define DSPWM_DEFS_SVH
`define DSPWM_OFF_CTRL_A 8'h00
`define DSPWM_OFF_CTRL_B 8'h04
`define DSPWM_OFF_COUNT 8'h08
`define DSPWM_OFF_CMP_A 8'h0C
`define DSPWM_OFF_CMP_B 8'h10
`define DSPWM_OFF_CAPT 8'h14
`define DSPWM_OFF_STATUS 8'h18
`define DSPWM_OFF_MASK 8'h1C
`define DSPWM_OFF_PINDIR 8'h20
`define DSPWM_ST_WRAP 0
`define DSPWM_ST_MATCH_A 1
`define DSPWM_ST_MATCH_B 2
`define DSPWM_ST_CAPT 3
`define DSPWM_RST16 16'h0000
`define DSPWM_MAX16 16'hFFFF
`define DSPWM_TOP8 16'h00FF
`define DSPWM_TOP9 16'h01FF
`define DSPWM_TOP10 16'h03FF
`define DSPWM_DIV8_MASK 10'h007
`define DSPWM_DIV64_MASK 10'h03F
`define DSPWM_DIV256_MASK 10'h0FF
`define DSPWM_DIV1024_MASK 10'h3FF
`define DSPWM_ACT_PORT 2'h0
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_CLEAR 2'h2
`define DSPWM_ACT_SET 2'h3
`endif

// ---- core/dspwm_pkg.sv ----
// types for the dual-slope pwm compare output block
package dspwm_pkg;
    typedef enum logic [1:0] {CLS_NORMAL, CLS_FAST, CLS_DUAL} dspwm_cls_t;
    typedef struct packed {
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [3:0] wave_mode_sel;
        logic [2:0] clk_sel;
    } dspwm_ctrl_t;
endpackage

// ---- core/dspwm_top.sv ----
// dual-slope pwm timer with compare outputs and wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "dspwm_defs.svh"
module dspwm_top
    import dspwm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt
    output logic irq,
    // normal port data for the two pins
    input wire logic port_a_data,
    input wire logic port_b_data,
    // pins
    output logic first_timer_chan_a_out,
    output logic first_timer_chan_a_oe,
    output logic first_timer_chan_b_out,
    output logic first_timer_chan_b_oe
);
    dspwm_ctrl_t ctrl_q;
    logic [15:0] count_value;
    logic dir_up_q;
    logic [1:0][15:0] cmp_buf_q;
    logic [1:0][15:0] cmp_q;
    logic [15:0] capture_top_reg;
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic [1:0] pin_direction_bit;
    logic [9:0] pre_q;
    logic [1:0] wave_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic req;
    logic wr_en;
    logic timer_tick;
    logic [15:0] top;
    dspwm_cls_t cls;
    logic [3:0] wm;
    logic top_hit;
    logic bottom_hit;
    logic up_phase;
    logic top_is_capt;
    logic load_cmp;
    logic cnt_wr;
    logic st_wr;
    logic [3:0] st_set;
    logic [1:0] match;
    logic [1:0] conn;
    logic [7:0] adr;
    logic [15:0] wdat16;

    assign wm = ctrl_q.wave_mode_sel;
    assign adr = {wb_adr_i[7:2], 2'b00};
    assign req = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wr_en = req && wb_we_i && ack_q;
    assign cnt_wr = wr_en && (adr == `DSPWM_OFF_COUNT);
    assign st_wr = wr_en && (adr == `DSPWM_OFF_STATUS);

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = nw[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    assign wdat16 = wb_dat_i[15:0];

    // mode class decoding drives everything downstream
    always_comb
    begin
        unique case (wm)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: cls = CLS_DUAL;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: cls = CLS_FAST;
            4'h0, 4'h4, 4'hC, 4'hD: cls = CLS_NORMAL;
        endcase
    end

    // top source per wave mode
    always_comb
    begin
        top_is_capt = 1'b0;
        unique case (wm)
            4'h1, 4'h5: top = `DSPWM_TOP8;
            4'h2, 4'h6: top = `DSPWM_TOP9;
            4'h3, 4'h7: top = `DSPWM_TOP10;
            4'h4, 4'h9, 4'hB, 4'hF: top = cmp_q[0];
            4'h8, 4'hA, 4'hC, 4'hE:
            begin
                top = capture_top_reg;
                top_is_capt = 1'b1;
            end
            4'h0, 4'hD: top = `DSPWM_MAX16;
        endcase
    end

    // prescaled tick; external sources are not modelled and stop it
    always_comb
    begin
        unique case (ctrl_q.clk_sel)
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (pre_q & `DSPWM_DIV8_MASK) == `DSPWM_DIV8_MASK;
            3'h3: timer_tick = (pre_q & `DSPWM_DIV64_MASK)
                               == `DSPWM_DIV64_MASK;
            3'h4: timer_tick = (pre_q & `DSPWM_DIV256_MASK)
                               == `DSPWM_DIV256_MASK;
            3'h5: timer_tick = pre_q == `DSPWM_DIV1024_MASK;
            3'h0, 3'h6, 3'h7: timer_tick = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pre_q <= 10'h000;
        end
        else if (ctrl_q.clk_sel == 3'h0)
        begin
            pre_q <= 10'h000;
        end
        else
        begin
            pre_q <= pre_q + 10'h001;
        end
    end

    assign top_hit = timer_tick && (count_value == top);
    assign bottom_hit = timer_tick && (count_value == `DSPWM_RST16);
    // bottom counts as rising, top as falling, for the steady extremes
    assign up_phase = (count_value == `DSPWM_RST16)
                      || (dir_up_q && (count_value != top));

    // counter: every step is qualified by the tick
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_value <= `DSPWM_RST16;
            dir_up_q <= 1'b1;
        end
        else if (cnt_wr)
        begin
            count_value <= merge16(count_value, wdat16, wb_sel_i);
        end
        else if (timer_tick)
        begin
            if (cls == CLS_DUAL)
            begin
                if (dir_up_q && count_value >= top)
                begin
                    dir_up_q <= 1'b0;
                    count_value <= count_value - 16'h0001;
                end
                else if (!dir_up_q && count_value == `DSPWM_RST16)
                begin
                    dir_up_q <= 1'b1;
                    count_value <= count_value + 16'h0001;
                end
                else if (dir_up_q)
                begin
                    count_value <= count_value + 16'h0001;
                end
                else
                begin
                    count_value <= count_value - 16'h0001;
                end
            end
            else
            begin
                dir_up_q <= 1'b1;
                if (wm != 4'h0 && count_value == top)
                begin
                    count_value <= `DSPWM_RST16;
                end
                else
                begin
                    count_value <= count_value + 16'h0001;
                end
            end
        end
    end

    // buffered compare loads: bottom in 8/9, top in phase correct,
    // wrap in fast pwm, at once otherwise
    always_comb
    begin
        unique case (wm)
            4'h8, 4'h9: load_cmp = bottom_hit;
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB: load_cmp = top_hit;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: load_cmp = top_hit;
            4'h0, 4'h4, 4'hC, 4'hD: load_cmp = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cmp_q <= '0;
        end
        else if (load_cmp)
        begin
            cmp_q <= cmp_buf_q;
        end
    end

    // interrupt sources; set wins over a same-cycle clear
    assign st_set[`DSPWM_ST_WRAP] = (cls == CLS_DUAL) ? bottom_hit
                                  : (cls == CLS_FAST) ? top_hit
                                  : (timer_tick
                                     && count_value == `DSPWM_MAX16);
    assign st_set[`DSPWM_ST_MATCH_A] = match[0];
    assign st_set[`DSPWM_ST_MATCH_B] = match[1];
    assign st_set[`DSPWM_ST_CAPT] = top_hit && top_is_capt;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= 4'h0;
        end
        else
        begin
            status_q <= (status_q & ~(st_wr ? wb_dat_i[3:0] : 4'h0))
                        | st_set;
        end
    end

    assign irq = |(status_q & mask_q);

    // register writes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= '0;
            cmp_buf_q <= '0;
            capture_top_reg <= `DSPWM_RST16;
            mask_q <= 4'h0;
            pin_direction_bit <= 2'h0;
        end
        else if (wr_en && wb_sel_i[0])
        begin
            unique case (adr)
                `DSPWM_OFF_CTRL_A:
                begin
                    ctrl_q.act_a <= wb_dat_i[7:6];
                    ctrl_q.act_b <= wb_dat_i[5:4];
                    ctrl_q.wave_mode_sel[1:0] <= wb_dat_i[1:0];
                end
                `DSPWM_OFF_CTRL_B:
                begin
                    ctrl_q.wave_mode_sel[3:2] <= wb_dat_i[4:3];
                    ctrl_q.clk_sel <= wb_dat_i[2:0];
                end
                `DSPWM_OFF_CMP_A:
                    cmp_buf_q[0] <= merge16(cmp_buf_q[0], wdat16, wb_sel_i);
                `DSPWM_OFF_CMP_B:
                    cmp_buf_q[1] <= merge16(cmp_buf_q[1], wdat16, wb_sel_i);
                `DSPWM_OFF_CAPT:
                    capture_top_reg <= merge16(capture_top_reg, wdat16,
                                               wb_sel_i);
                `DSPWM_OFF_MASK: mask_q <= wb_dat_i[3:0];
                `DSPWM_OFF_PINDIR: pin_direction_bit <= wb_dat_i[1:0];
                default: ;
            endcase
        end
        else if (wr_en && wb_sel_i[1])
        begin
            unique case (adr)
                `DSPWM_OFF_CMP_A:
                    cmp_buf_q[0] <= merge16(cmp_buf_q[0], wdat16, wb_sel_i);
                `DSPWM_OFF_CMP_B:
                    cmp_buf_q[1] <= merge16(cmp_buf_q[1], wdat16, wb_sel_i);
                `DSPWM_OFF_CAPT:
                    capture_top_reg <= merge16(capture_top_reg, wdat16,
                                               wb_sel_i);
                default: ;
            endcase
        end
    end

    // ack one cycle after the request, read data captured with it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            unique case (adr)
                `DSPWM_OFF_CTRL_A: rdat_q <= {24'h0, ctrl_q.act_a,
                                   ctrl_q.act_b, 2'h0,
                                   ctrl_q.wave_mode_sel[1:0]};
                `DSPWM_OFF_CTRL_B: rdat_q <= {27'h0,
                                   ctrl_q.wave_mode_sel[3:2],
                                   ctrl_q.clk_sel};
                `DSPWM_OFF_COUNT: rdat_q <= {16'h0, count_value};
                `DSPWM_OFF_CMP_A: rdat_q <= {16'h0, cmp_buf_q[0]};
                `DSPWM_OFF_CMP_B: rdat_q <= {16'h0, cmp_buf_q[1]};
                `DSPWM_OFF_CAPT: rdat_q <= {16'h0, capture_top_reg};
                `DSPWM_OFF_STATUS: rdat_q <= {28'h0, status_q};
                `DSPWM_OFF_MASK: rdat_q <= {28'h0, mask_q};
                `DSPWM_OFF_PINDIR: rdat_q <= {30'h0, pin_direction_bit};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // waveform generation, one block per channel
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
        logic [1:0] act;
        logic toggle_ok;
        assign act = (i == 0) ? ctrl_q.act_a : ctrl_q.act_b;
        // toggling exists for chan B only in non-pwm modes
        assign toggle_ok = (cls == CLS_NORMAL)
                           || (i == 0 && cls == CLS_FAST
                               && (wm == 4'hE || wm == 4'hF))
                           || (i == 0 && cls == CLS_DUAL
                               && (wm == 4'h9 || wm == 4'hB));
        assign conn[i] = (act != `DSPWM_ACT_PORT)
                         && (act != `DSPWM_ACT_TOGGLE || toggle_ok);
        assign match[i] = timer_tick && (count_value == cmp_q[i]);

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                wave_q[i] <= 1'b0;
            end
            else if (conn[i])
            begin
                unique case (cls)
                    CLS_NORMAL:
                    begin
                        if (match[i])
                        begin
                            unique case (act)
                                `DSPWM_ACT_TOGGLE: wave_q[i] <= !wave_q[i];
                                `DSPWM_ACT_CLEAR: wave_q[i] <= 1'b0;
                                `DSPWM_ACT_SET: wave_q[i] <= 1'b1;
                                default: ;
                            endcase
                        end
                    end
                    CLS_FAST:
                    begin
                        if (act == `DSPWM_ACT_TOGGLE)
                        begin
                            if (match[i])
                            begin
                                wave_q[i] <= !wave_q[i];
                            end
                        end
                        // a match at top is dropped; the bottom action wins
                        else if (top_hit)
                        begin
                            wave_q[i] <= (act == `DSPWM_ACT_CLEAR);
                        end
                        else if (match[i])
                        begin
                            wave_q[i] <= (act == `DSPWM_ACT_SET);
                        end
                    end
                    CLS_DUAL:
                    begin
                        if (act == `DSPWM_ACT_TOGGLE)
                        begin
                            if (match[i])
                            begin
                                wave_q[i] <= !wave_q[i];
                            end
                        end
                        else if (match[i])
                        begin
                            wave_q[i] <= up_phase
                                         ? (act == `DSPWM_ACT_SET)
                                         : (act == `DSPWM_ACT_CLEAR);
                        end
                    end
                endcase
            end
        end
    end

    assign first_timer_chan_a_out = conn[0] ? wave_q[0] : port_a_data;
    assign first_timer_chan_b_out = conn[1] ? wave_q[1] : port_b_data;
    assign first_timer_chan_a_oe = pin_direction_bit[0];
    assign first_timer_chan_b_oe = pin_direction_bit[1];

    AST_PFC_LOAD_BOTTOM: assert property (
        @(posedge mclk) disable iff (rst)
        ((wm == 4'h8) && $past(wm == 4'h8) && (cmp_q[1] != $past(cmp_q[1])))
        |-> $past(bottom_hit))
        else $error("compare loaded away from bottom");
    AST_DUAL_NONINV_UP: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_DUAL && ctrl_q.act_b == `DSPWM_ACT_CLEAR && match[1]
         && up_phase) |=> !wave_q[1])
        else $error("non-inverted output not cleared on rising match");
    AST_DUAL_INV_DOWN: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_DUAL && ctrl_q.act_b == `DSPWM_ACT_SET && match[1]
         && !up_phase) |=> !wave_q[1])
        else $error("inverted output not cleared on falling match");
    AST_PIN_DRIVER: assert property (
        @(posedge mclk) disable iff (rst)
        !pin_direction_bit[1] |-> !first_timer_chan_b_oe)
        else $error("pin driven without direction bit");
    AST_M9_TOGGLE: assert property (
        @(posedge mclk) disable iff (rst)
        (wm == 4'h9 && ctrl_q.act_a == `DSPWM_ACT_TOGGLE && match[0])
        |=> wave_q[0] != $past(wave_q[0]))
        else $error("mode 9 toggle missing");
    AST_TICK_ENABLE: assert property (
        @(posedge mclk) disable iff (rst)
        (!timer_tick && !cnt_wr) |=> count_value == $past(count_value))
        else $error("counter moved without tick");
    AST_OVERRIDE: assert property (
        @(posedge mclk) disable iff (rst)
        (ctrl_q.act_a == `DSPWM_ACT_SET)
        |-> first_timer_chan_a_out == wave_q[0])
        else $error("action field did not take the pin");
    AST_NONPWM_SET: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_NORMAL && ctrl_q.act_a == `DSPWM_ACT_SET && match[0])
        |=> wave_q[0])
        else $error("non-pwm set on match missing");
    AST_FAST_BOTTOM: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_FAST && ctrl_q.act_b == `DSPWM_ACT_CLEAR && top_hit)
        |=> wave_q[1] && count_value == 16'h0000)
        else $error("fast pwm bottom set missing");
    AST_FAST_B_PORT: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_FAST && ctrl_q.act_b == `DSPWM_ACT_TOGGLE)
        |-> first_timer_chan_b_out == port_b_data)
        else $error("chan B toggle in fast pwm");
    AST_FAST_TOP_IGNORE: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_FAST && ctrl_q.act_a == `DSPWM_ACT_SET && top_hit)
        |=> !wave_q[0])
        else $error("fast pwm match at top not ignored");
    AST_DUAL_TURN: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_DUAL && top_hit && dir_up_q && !cnt_wr
         && $stable(wm)) |=> !dir_up_q)
        else $error("dual-slope count did not turn at top");
    AST_WRAP_BOTTOM: assert property (
        @(posedge mclk) disable iff (rst)
        (cls == CLS_DUAL && bottom_hit) |=> status_q[`DSPWM_ST_WRAP])
        else $error("wrap flag missed at bottom");
    COV_PFC_PERIOD: cover property (@(posedge mclk) disable iff (rst)
        wm == 4'h9 && top_hit ##[1:300] bottom_hit);
    COV_FAST_PWM: cover property (@(posedge mclk) disable iff (rst)
        cls == CLS_FAST && conn[1] && top_hit);
    COV_IRQ: cover property (@(posedge mclk) disable iff (rst)
        $rose(irq));
endmodule // dspwm_top
`default_nettype wire

// ---- test/dspwm_top_bench.sv ----
// self-checking bench for the dual-slope pwm compare output block
`timescale 1ns/1ns
`default_nettype none
module dspwm_top_bench;
    import dspwm_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000, rdat, r;
    logic ack, irq, pa = 1'b1, pb = 1'b0, oa, oea, ob, oeb;
    logic [31:0] h;
    int n_mismatch = 0, n_checks = 0;
    always #20 mclk = ~mclk;
    dspwm_top dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .port_a_data(pa),
        .port_b_data(pb), .first_timer_chan_a_out(oa),
        .first_timer_chan_a_oe(oea), .first_timer_chan_b_out(ob),
        .first_timer_chan_b_oe(oeb));
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; the request is held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (ack !== 1'b1 && i < 50);
        q = rdat;
        if (i >= 50)
            n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // settles two windows, then counts the high samples on one pin
    task automatic measure(input int win, input logic on_b,
        output logic [31:0] hi);
        repeat (2 * win) @(posedge mclk);
        hi = 32'h00000000;
        repeat (win)
        begin
            @(negedge mclk);
            if ((on_b ? ob : oa) === 1'b1)
                hi = hi + 32'h00000001;
        end
    endtask
    // stops the timer first so every case starts from count zero
    task automatic run(input logic [7:0] ca, input logic [7:0] cb,
        input logic [15:0] a, input logic [15:0] b, input logic [15:0] t,
        input int win, input logic on_b, output logic [31:0] hi);
        logic [31:0] q;
        wb(1'b1, 8'h04, 32'h00000000, q);
        wb(1'b1, 8'h08, 32'h00000000, q);
        wb(1'b1, 8'h0C, {16'h0000, a}, q);
        wb(1'b1, 8'h10, {16'h0000, b}, q);
        wb(1'b1, 8'h14, {16'h0000, t}, q);
        wb(1'b1, 8'h20, 32'h00000003, q);
        wb(1'b1, 8'h00, {24'h000000, ca}, q);
        wb(1'b1, 8'h04, {24'h000000, cb}, q);
        measure(win, on_b, hi);
    endtask
    task automatic t_reset();
        wb(1'b0, 8'h00, 32'h00000000, r);
        chk(r, 32'h00000000);
        chk({30'h0, oea, oeb}, 32'h00000000);
        chk({30'h0, oa, ob}, {30'h0, pa, pb});
        wb(1'b0, 8'h40, 32'h00000000, r);
        chk(r, 32'h00000000);
    endtask
    // mode 8, top 0x10 from capture reg, period 32 ticks
    task automatic t_dual();
        run(8'h20, 8'h11, 16'h0000, 16'h0004, 16'h0010, 32, 1'b1, h);
        chk(h, 32'h00000008);
        // new compare written while running takes hold at bottom
        wb(1'b1, 8'h10, 32'h00000008, r);
        measure(32, 1'b1, h);
        chk(h, 32'h00000010);
        run(8'h30, 8'h11, 16'h0000, 16'h0004, 16'h0010, 32, 1'b1, h);
        chk(h, 32'h00000018);
        run(8'h20, 8'h11, 16'h0000, 16'h0000, 16'h0010, 32, 1'b1, h);
        chk(h, 32'h00000000);
        run(8'h20, 8'h11, 16'h0000, 16'h0010, 16'h0010, 32, 1'b1, h);
        chk(h, 32'h00000020);
        run(8'h30, 8'h11, 16'h0000, 16'h0000, 16'h0010, 32, 1'b1, h);
        chk(h, 32'h00000020);
        run(8'h20, 8'h12, 16'h0000, 16'h0004, 16'h0010, 256, 1'b1, h);
        chk(h, 32'h00000040);
    endtask
    task automatic t_mode9();
        run(8'h41, 8'h11, 16'h0010, 16'h0000, 16'h0000, 64, 1'b0, h);
        chk(h, 32'h00000020);
    endtask
    // ctc mode 4 with top from chan A compare
    task automatic t_nonpwm();
        run(8'h30, 8'h09, 16'h0007, 16'h0003, 16'h0000, 16, 1'b1, h);
        chk(h, 32'h00000010);
        run(8'hE0, 8'h09, 16'h0007, 16'h0003, 16'h0000, 16, 1'b1, h);
        chk(h, 32'h00000000);
        run(8'h40, 8'h09, 16'h0007, 16'h0000, 16'h0000, 16, 1'b0, h);
        chk(h, 32'h00000008);
    endtask
    // fast mode 14 top 0x10 gives 17 ticks, mode 15 top 7 gives 8;
    // mode 5 leaves action 1 on both pins as port pins
    task automatic t_fast();
        run(8'h22, 8'h19, 16'h0000, 16'h0004, 16'h0010, 17, 1'b1, h);
        chk(h, 32'h00000005);
        run(8'hF2, 8'h19, 16'h0000, 16'h0004, 16'h0010, 17, 1'b1, h);
        chk(h, 32'h0000000C);
        run(8'h22, 8'h19, 16'h0000, 16'h0010, 16'h0010, 17, 1'b1, h);
        chk(h, 32'h00000011);
        run(8'h43, 8'h19, 16'h0007, 16'h0000, 16'h0000, 16, 1'b0, h);
        chk(h, 32'h00000008);
        run(8'h51, 8'h09, 16'h0007, 16'h0000, 16'h0010, 16, 1'b0, h);
        chk(h, 32'h00000010);
    endtask
    task automatic t_pins();
        wb(1'b1, 8'h00, 32'h00000020, r);
        wb(1'b1, 8'h20, 32'h00000001, r);
        @(negedge mclk);
        chk({30'h0, oea, oeb}, 32'h00000002);
        chk({31'h0, oa}, {31'h0, pa});
    endtask
    task automatic t_irq();
        run(8'h20, 8'h11, 16'h0000, 16'h0004, 16'h0010, 32, 1'b1, h);
        wb(1'b1, 8'h1C, 32'h00000001, r);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h00000001);
        wb(1'b0, 8'h18, 32'h00000000, r);
        chk(r & 32'h00000001, 32'h00000001);
        wb(1'b1, 8'h1C, 32'h00000000, r);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h00000000);
        wb(1'b1, 8'h1C, 32'h00000001, r);
        wb(1'b1, 8'h04, 32'h00000000, r);
        wb(1'b1, 8'h18, 32'h0000000F, r);
        wb(1'b0, 8'h18, 32'h00000000, r);
        chk(r, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_dual();
        t_mode9();
        t_nonpwm();
        t_fast();
        t_pins();
        t_irq();
        final_report();
    end
    // the whole run needs well under 8000 cycles
    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        final_report();
    end
endmodule // dspwm_top_bench
`default_nettype wire
